// ==== design/upic_pkg.sv ====
// constants and types for the uplink port interface mode configuration
// assumes a single 50 MHz core clock domain
package upic_pkg;
	// register location and field positions
	localparam logic [7:0] UPIC_REG_ADDR = 8'h56;
	localparam int UPIC_BIT_RMII_CLK = 7;
	localparam int UPIC_BIT_GIG = 6;
	localparam int UPIC_BIT_RSVD = 5;
	localparam int UPIC_BIT_ING_DLY = 4;
	localparam int UPIC_BIT_EGR_DLY = 3;
	localparam int UPIC_BIT_MAC_ROLE = 2;
	localparam int UPIC_BIT_IFACE_LO = 0;
	// reset values of bits with no strap behind them
	localparam logic UPIC_RST_RSVD = 1'b1;
	localparam logic UPIC_RST_ING_DLY = 1'b0;
	localparam logic UPIC_RST_EGR_DLY = 1'b1;
	localparam logic [7:0] UPIC_RDATA_NONE = 8'h00;
	// interface type encoding
	localparam logic [1:0] UPIC_IF_MII = 2'h0;
	localparam logic [1:0] UPIC_IF_RMII = 2'h1;
	localparam logic [1:0] UPIC_IF_GMII = 2'h2;
	localparam logic [1:0] UPIC_IF_RGMII = 2'h3;
	// timing
	localparam int UPIC_CLK_PERIOD_PS = 20000;
	localparam int UPIC_ID_DELAY_PS = 1500;
	localparam int UPIC_ID_DELAY_RAW =
		(UPIC_ID_DELAY_PS + UPIC_CLK_PERIOD_PS - 1) / UPIC_CLK_PERIOD_PS;
	localparam int UPIC_ID_DELAY_CYC =
		(UPIC_ID_DELAY_RAW < 1) ? 1 : UPIC_ID_DELAY_RAW;
	localparam int UPIC_MII100_HALF_PS = 20000;
	localparam int UPIC_MII10_HALF_PS = 200000;
	localparam int UPIC_MII100_HALF_CYC =
		UPIC_MII100_HALF_PS / UPIC_CLK_PERIOD_PS;
	localparam int UPIC_MII10_HALF_CYC = UPIC_MII10_HALF_PS / UPIC_CLK_PERIOD_PS;
	localparam logic [4:0] UPIC_LINK_WATCH_CYC = 5'h10;

	typedef struct packed {
		logic rmii_int_clk;
		logic gig;
		logic rsvd;
		logic ing_dly;
		logic egr_dly;
		logic mac_role;
		logic [1:0] iface;
	} upic_ctrl_s;

	typedef struct packed {
		logic crs;
		logic col;
		logic rxc;
		logic txc;
	} upic_pin_oe_s;
endpackage

// ==== design/upic_sync.sv ====
// two flip-flop synchroniser, one chain per bit
// assumes inputs are asynchronous to core_clk_in; no reset, data only
`timescale 1ns/1ns
`default_nettype none
module upic_sync #(
	parameter int W = 1
) (
	input wire logic core_clk_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta;
			logic stable;
			always_ff @(posedge core_clk_in) begin
				meta <= async_in[i];
				stable <= meta;
			end
			assign sync_out[i] = stable;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== design/upic_top.sv ====
// uplink port interface mode configuration register and pin direction control
// assumes a register port on the core clock; straps and pins are asynchronous
//
// Operation
// - bit 7 set runs rmii from internal reference clock, clear uses external
// - rmii clock bit resets from shared strap; pull-up selects internal clock
// - bit 6 set runs gigabit in gmii or rgmii, clear runs 10/100
// - in 10/100 operation a global control bit picks 10 or 100
// - gigabit bit resets from its own strap; pull-up selects gigabit
// - bit 4 set adds ingress rgmii clock delay, reset value 0
// - bit 3 set adds egress rgmii clock delay, reset value 1
// - bit 2 set gives mac role, clear gives phy role
// - role bit resets from shared strap; pull-up selects mac role
// - gmii phy role drives carrier sense and collision as outputs
// - mii phy role drives crs, col, rx clock and tx clock
// - bits 1:0 select mii, rmii, gmii or rgmii
// - interface field resets from two-pin strap, default rgmii
`timescale 1ns/1ns
`default_nettype none
module upic_top (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic clock_and_role_strap_pin_in,
	input wire logic speed_strap_pin_in,
	input wire logic [1:0] interface_type_strap_pins_in,
	input wire logic global_speed_100_in,
	input wire logic ext_ref_clk_in,
	input wire logic crs_pin_in,
	input wire logic col_pin_in,
	input wire logic phy_crs_src_in,
	input wire logic phy_col_src_in,
	output logic [1:0] iface_mode_out,
	output logic rmii_int_clk_out,
	output logic gigabit_speed_select_out,
	output logic speed_100_out,
	output logic mac_role_out,
	output logic rx_delay_en_out,
	output logic tx_delay_en_out,
	output logic ext_clk_ok_out,
	output logic crs_out,
	output logic crs_oe_out,
	output logic col_out,
	output logic col_oe_out,
	output logic mac_crs_out,
	output logic mac_col_out,
	output logic rxc_out,
	output logic rxc_oe_out,
	output logic txc_out,
	output logic txc_oe_out
);
	logic [6:0] pin_sync;
	logic strap_clk_role;
	logic strap_speed;
	logic [1:0] strap_iface;
	logic ref_clk_s;
	logic crs_s;
	logic col_s;

	upic_sync #(.W(7)) u_sync (
		.core_clk_in(core_clk_in),
		.async_in({clock_and_role_strap_pin_in, speed_strap_pin_in,
			interface_type_strap_pins_in, ext_ref_clk_in, crs_pin_in,
			col_pin_in}),
		.sync_out(pin_sync)
	);
	assign strap_clk_role = pin_sync[6];
	assign strap_speed = pin_sync[5];
	assign strap_iface = pin_sync[4:3];
	assign ref_clk_s = pin_sync[2];
	assign crs_s = pin_sync[1];
	assign col_s = pin_sync[0];

	function automatic logic phy_mode(input upic_pkg::upic_ctrl_s c,
		input logic [1:0] kind);
		phy_mode = !c.mac_role && (c.iface == kind);
	endfunction

	// control register
	upic_pkg::upic_ctrl_s ctrl;
	upic_pkg::upic_ctrl_s next_ctrl;
	logic wr_hit;

	assign wr_hit = reg_wr_in && (reg_addr_in == upic_pkg::UPIC_REG_ADDR);

	always_comb begin
		next_ctrl = ctrl;
		if (rst_in) begin
			// straps are followed for the whole reset, last value wins
			next_ctrl.rmii_int_clk = strap_clk_role;
			next_ctrl.gig = strap_speed;
			next_ctrl.rsvd = upic_pkg::UPIC_RST_RSVD;
			next_ctrl.ing_dly = upic_pkg::UPIC_RST_ING_DLY;
			next_ctrl.egr_dly = upic_pkg::UPIC_RST_EGR_DLY;
			next_ctrl.mac_role = strap_clk_role;
			next_ctrl.iface = strap_iface;
		end else if (wr_hit) begin
			next_ctrl = upic_pkg::upic_ctrl_s'(reg_wdata_in);
			next_ctrl.rsvd = upic_pkg::UPIC_RST_RSVD;
		end
	end

	always_ff @(posedge core_clk_in) begin
		ctrl <= next_ctrl;
	end

	// read data, one cycle after the address
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = upic_pkg::UPIC_RDATA_NONE;
		if (reg_addr_in == upic_pkg::UPIC_REG_ADDR) begin
			next_rdata = ctrl;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= upic_pkg::UPIC_RDATA_NONE;
		end else begin
			reg_rdata_out <= next_rdata;
		end
	end

	// mode outputs follow the register one cycle later
	upic_pkg::upic_pin_oe_s next_oe;

	always_comb begin
		next_oe = '0;
		if (phy_mode(ctrl, upic_pkg::UPIC_IF_GMII)) begin
			next_oe.crs = 1'b1;
			next_oe.col = 1'b1;
		end
		if (phy_mode(ctrl, upic_pkg::UPIC_IF_MII)) begin
			next_oe = '1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			iface_mode_out <= upic_pkg::UPIC_IF_RGMII;
			rmii_int_clk_out <= 1'b1;
			gigabit_speed_select_out <= 1'b1;
			speed_100_out <= 1'b0;
			mac_role_out <= 1'b1;
			rx_delay_en_out <= 1'b0;
			tx_delay_en_out <= 1'b0;
			crs_oe_out <= 1'b0;
			col_oe_out <= 1'b0;
			rxc_oe_out <= 1'b0;
			txc_oe_out <= 1'b0;
		end else begin
			iface_mode_out <= ctrl.iface;
			rmii_int_clk_out <= ctrl.rmii_int_clk;
			gigabit_speed_select_out <= ctrl.gig;
			speed_100_out <= !ctrl.gig && global_speed_100_in;
			mac_role_out <= ctrl.mac_role;
			// the delay cells sit in the pads; only rgmii uses them
			rx_delay_en_out <= ctrl.ing_dly &&
				(ctrl.iface == upic_pkg::UPIC_IF_RGMII);
			tx_delay_en_out <= ctrl.egr_dly &&
				(ctrl.iface == upic_pkg::UPIC_IF_RGMII);
			crs_oe_out <= next_oe.crs;
			col_oe_out <= next_oe.col;
			rxc_oe_out <= next_oe.rxc;
			txc_oe_out <= next_oe.txc;
		end
	end

	// crs and col: driven from the datapath in mii or gmii phy role, sensed in mac role
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			crs_out <= 1'b0;
			col_out <= 1'b0;
			mac_crs_out <= 1'b0;
			mac_col_out <= 1'b0;
		end else begin
			crs_out <= phy_crs_src_in;
			col_out <= phy_col_src_in;
			mac_crs_out <= ctrl.mac_role & crs_s;
			mac_col_out <= ctrl.mac_role & col_s;
		end
	end

	// mii clocks made in phy role: 25 MHz or 2.5 MHz from the core clock
	logic [3:0] div_cnt;
	logic [3:0] next_div_cnt;
	logic mii_clk;
	logic next_mii_clk;
	logic [3:0] half_last;

	assign half_last = global_speed_100_in ?
		4'(upic_pkg::UPIC_MII100_HALF_CYC - 1) :
		4'(upic_pkg::UPIC_MII10_HALF_CYC - 1);

	always_comb begin
		next_div_cnt = div_cnt + 4'h1;
		next_mii_clk = mii_clk;
		if (div_cnt >= half_last) begin
			next_div_cnt = 4'h0;
			next_mii_clk = !mii_clk;
		end
		if (rst_in) begin
			next_div_cnt = 4'h0;
			next_mii_clk = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		div_cnt <= next_div_cnt;
		mii_clk <= next_mii_clk;
	end

	// egress clock may be held back by whole cycles, the delay rounded up
	localparam int DW = upic_pkg::UPIC_ID_DELAY_CYC;
	logic [DW-1:0] tx_pipe;
	logic [DW-1:0] next_tx_pipe;
	logic next_txc;

	always_comb begin
		next_tx_pipe = DW'({tx_pipe, mii_clk});
		next_txc = ctrl.egr_dly ? tx_pipe[DW-1] : mii_clk;
		if (rst_in) begin
			next_tx_pipe = '0;
			next_txc = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		tx_pipe <= next_tx_pipe;
		txc_out <= next_txc;
		rxc_out <= rst_in ? 1'b0 : mii_clk;
	end

	// external reference clock watch: normal rmii mode needs its edges
	logic ref_prev;
	logic [4:0] watch_cnt;
	logic [4:0] next_watch_cnt;
	logic next_clk_ok;

	always_comb begin
		next_watch_cnt = watch_cnt;
		if (ref_clk_s != ref_prev) begin
			next_watch_cnt = 5'h0;
		end else if (watch_cnt != upic_pkg::UPIC_LINK_WATCH_CYC) begin
			next_watch_cnt = watch_cnt + 5'h1;
		end
		// internal clock mode does not depend on the partner's clock
		next_clk_ok = ctrl.rmii_int_clk ||
			(next_watch_cnt != upic_pkg::UPIC_LINK_WATCH_CYC);
		if (rst_in) begin
			next_watch_cnt = upic_pkg::UPIC_LINK_WATCH_CYC;
			next_clk_ok = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		ref_prev <= ref_clk_s;
		watch_cnt <= next_watch_cnt;
		ext_clk_ok_out <= next_clk_ok;
	end

	// checks
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	a_write_takes: assert property (wr_hit ##1 !wr_hit[*2]
		|-> ##1 reg_rdata_out == ({$past(reg_wdata_in, 3)} |
		8'h20) || $past(reg_addr_in) != upic_pkg::UPIC_REG_ADDR)
		else $error("write did not reach register");
	a_rsvd_one: assert property (ctrl.rsvd == 1'b1)
		else $error("reserved bit not one");
	a_gmii_phy_pins: assert property (
		phy_mode(ctrl, upic_pkg::UPIC_IF_GMII) ##1 $stable(ctrl)
		|-> crs_oe_out && col_oe_out && !rxc_oe_out && !txc_oe_out)
		else $error("gmii phy role pin directions wrong");
	a_mii_phy_pins: assert property (
		phy_mode(ctrl, upic_pkg::UPIC_IF_MII) ##1 $stable(ctrl)
		|-> crs_oe_out && col_oe_out && rxc_oe_out && txc_oe_out)
		else $error("mii phy role pin directions wrong");
	a_mac_role_in: assert property (
		ctrl.mac_role |=> !crs_oe_out && !col_oe_out && !txc_oe_out)
		else $error("mac role drives a sense pin");
	a_mode_follows: assert property (1'b1 |=> iface_mode_out ==
		$past(ctrl.iface) && rmii_int_clk_out == $past(ctrl.rmii_int_clk))
		else $error("interface mode output lags wrongly");
	a_speed_pick: assert property (1'b1 |=> speed_100_out ==
		(!$past(ctrl.gig) && $past(global_speed_100_in)))
		else $error("10/100 speed choice wrong");
	a_rx_delay: assert property (
		ctrl.ing_dly && ctrl.iface == upic_pkg::UPIC_IF_RGMII
		|=> rx_delay_en_out)
		else $error("ingress delay not enabled");
	a_strap_load: assert property (@(posedge core_clk_in) disable iff (1'b0)
		$fell(rst_in) |-> ctrl.mac_role == ctrl.rmii_int_clk
		&& ctrl.egr_dly && !ctrl.ing_dly)
		else $error("strap value not loaded at reset");
endmodule
`default_nettype wire

// ==== tb/upic_partner.sv ====
// link partner model: reference clock and carrier sense/collision drive
// assumes the bench resolves the shared pins from the device's enables
`timescale 1ns/1ns
`default_nettype none
module upic_partner (
	input wire logic run_clk_in,
	input wire logic our_rx_dly_in,
	input wire logic our_tx_dly_in,
	input wire logic crs_in,
	input wire logic col_in,
	output logic ref_clk_out,
	output logic crs_out,
	output logic col_out,
	output logic rx_dly_out,
	output logic tx_dly_out
);
	initial ref_clk_out = 1'b0;
	// clock stands still outside traffic, as a stopped reference would
	always begin
		#80;
		if (run_clk_in) ref_clk_out = !ref_clk_out;
	end
	assign crs_out = crs_in;
	assign col_out = col_in;
	// only one side adds each direction's delay
	assign rx_dly_out = !our_tx_dly_in;
	assign tx_dly_out = !our_rx_dly_in;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the uplink interface mode configuration
// assumes upic_top and upic_partner are compiled before this file
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic cr_strap = 1'b1;
	logic sp_strap = 1'b1;
	logic [1:0] if_strap = 2'h3;
	logic g100 = 1'b0;
	logic run_clk = 1'b0;
	logic p_drv = 1'b0;
	logic src_crs = 1'b0;
	logic [7:0] rdata;
	logic [1:0] iface;
	logic rmii, gig, s100, mac, rxd, txd, ok;
	logic crs_o, crs_oe, col_o, col_oe, rxc_oe, txc_oe;
	logic ref_clk, p_crs, p_col;
	logic mcrs, mcol, rxc, txc, p_rxd, p_txd;
	logic [7:0] d;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	// shared pins: the device wins while its enable is high
	wire logic crs_w = crs_oe ? crs_o : p_crs;
	wire logic col_w = col_oe ? col_o : p_col;
	always #10 clk = !clk;
	upic_top upic_top_i (.core_clk_in(clk), .rst_in(rst),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .clock_and_role_strap_pin_in(cr_strap),
		.speed_strap_pin_in(sp_strap), .interface_type_strap_pins_in(if_strap),
		.global_speed_100_in(g100), .ext_ref_clk_in(ref_clk),
		.crs_pin_in(crs_w), .col_pin_in(col_w), .phy_crs_src_in(src_crs),
		.phy_col_src_in(!src_crs), .iface_mode_out(iface),
		.rmii_int_clk_out(rmii), .gigabit_speed_select_out(gig),
		.speed_100_out(s100), .mac_role_out(mac), .rx_delay_en_out(rxd),
		.tx_delay_en_out(txd), .ext_clk_ok_out(ok), .crs_out(crs_o),
		.crs_oe_out(crs_oe), .col_out(col_o), .col_oe_out(col_oe),
		.mac_crs_out(mcrs), .mac_col_out(mcol), .rxc_out(rxc),
		.rxc_oe_out(rxc_oe), .txc_out(txc), .txc_oe_out(txc_oe));
	upic_partner upic_partner_i (.run_clk_in(run_clk), .our_rx_dly_in(rxd),
		.our_tx_dly_in(txd), .crs_in(p_drv), .col_in(!p_drv),
		.ref_clk_out(ref_clk), .crs_out(p_crs), .col_out(p_col),
		.rx_dly_out(p_rxd), .tx_dly_out(p_txd));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 3000) begin
			failures++;
			test_done();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_reset(input logic cr, input logic sp, input logic [1:0] t);
		@(posedge clk);
		rst <= 1'b1;
		cr_strap <= cr;
		sp_strap <= sp;
		if_strap <= t;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		tick(2);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		tick(3);
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		tick(2);
		v = rdata;
	endtask
	task automatic t_defaults();
		reg_rd(upic_pkg::UPIC_REG_ADDR, d);
		chk("reg", 8'hef, d);
		chk("iface", 8'h03, {6'h00, iface});
		chk("rmii", 8'h01, {7'h00, rmii});
		chk("gig", 8'h01, {7'h00, gig});
		chk("mac", 8'h01, {7'h00, mac});
		chk("dly", 8'h01, {6'h00, rxd, txd});
		chk("ok", 8'h01, {7'h00, ok});
		$display("test defaults done");
	endtask
	task automatic t_straps_low();
		do_reset(1'b0, 1'b0, 2'h0);
		reg_rd(upic_pkg::UPIC_REG_ADDR, d);
		chk("reg", 8'h28, d);
		chk("oe", 8'h0f, {4'h0, crs_oe, col_oe, rxc_oe, txc_oe});
		src_crs <= 1'b1;
		g100 <= 1'b1;
		tick(4);
		chk("crs", 8'h02, {6'h00, crs_w, col_w});
		chk("sense", 8'h00, {6'h00, mcrs, mcol});
		chk("s100", 8'h01, {7'h00, s100});
		g100 <= 1'b0;
		tick(20);
		chk("s10", 8'h00, {7'h00, s100});
		chk("ok_stop", 8'h00, {7'h00, ok});
		run_clk <= 1'b1;
		tick(40);
		chk("ok_run", 8'h01, {7'h00, ok});
		run_clk <= 1'b0;
		tick(30);
		chk("ok_drop", 8'h00, {7'h00, ok});
		$display("test straps_low done");
	endtask
	task automatic t_modes();
		logic [1:0] m;
		logic [3:0] oe;
		do_reset(1'b1, 1'b1, 2'h3);
		g100 <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			oe = (m == 2'h0) ? 4'hf : ((m == 2'h2) ? 4'hc : 4'h0);
			reg_wr(upic_pkg::UPIC_REG_ADDR, {6'h32, m});
			reg_rd(upic_pkg::UPIC_REG_ADDR, d);
			chk("reg", {6'h3a, m}, d);
			chk("iface", {6'h00, m}, {6'h00, iface});
			chk("oe", {4'h0, oe}, {4'h0, crs_oe, col_oe, rxc_oe, txc_oe});
			chk("txd", {7'h00, m == 2'h3}, {7'h00, txd});
			chk("s100", 8'h00, {7'h00, s100});
		end
		reg_wr(upic_pkg::UPIC_REG_ADDR, 8'hd7);
		chk("dly", 8'h02, {6'h00, rxd, txd});
		chk("mac", 8'h01, {7'h00, mac});
		chk("oe", 8'h00, {4'h0, crs_oe, col_oe, rxc_oe, txc_oe});
		chk("p_dly", 8'h02, {6'h00, p_rxd, p_txd});
		chk("sense", 8'h01, {6'h00, mcrs, mcol});
		p_drv <= 1'b1;
		tick(4);
		chk("sense", 8'h02, {6'h00, mcrs, mcol});
		p_drv <= 1'b0;
		reg_wr(8'h57, 8'h00);
		reg_rd(upic_pkg::UPIC_REG_ADDR, d);
		chk("reg", 8'hf7, d);
		reg_rd(8'h57, d);
		chk("unmapped", 8'h00, d);
		$display("test modes done");
	endtask
	task automatic t_clocks();
		logic prev;
		int lag_err;
		int flips;
		reg_wr(upic_pkg::UPIC_REG_ADDR, 8'h08);
		lag_err = 0;
		flips = 0;
		prev = rxc;
		repeat (8) begin
			tick(1);
			if (txc !== prev) lag_err++;
			if (rxc !== prev) flips++;
			prev = rxc;
		end
		chk("txc_lag", 8'h00, 8'(lag_err));
		chk("rxc_100", 8'h08, 8'(flips));
		reg_wr(upic_pkg::UPIC_REG_ADDR, 8'h00);
		lag_err = 0;
		repeat (8) begin
			tick(1);
			if (txc !== rxc) lag_err++;
		end
		chk("txc_same", 8'h00, 8'(lag_err));
		g100 <= 1'b0;
		tick(12);
		flips = 0;
		prev = rxc;
		repeat (40) begin
			tick(1);
			if (rxc !== prev) flips++;
			prev = rxc;
		end
		chk("rxc_10", 8'h04, 8'(flips));
		$display("test clocks done");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		t_defaults();
		t_straps_low();
		t_modes();
		t_clocks();
		test_done();
	end
endmodule
`default_nettype wire
